// ### src/sfs_params.svh
// Offsets, field positions, reset values and timing counts of the shared flash select block
`ifndef SFS_PARAMS_SVH
`define SFS_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SFS_OFS_CTRL        8'h00
`define SFS_OFS_PARK        8'h04
`define SFS_OFS_DATA        8'h08
`define SFS_OFS_STATUS      8'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SFS_CTRL_DRIVE      0
`define SFS_CTRL_SELECT     1
`define SFS_CTRL_VS_LSB     4
`define SFS_CTRL_VS_OE      7

// ----------------------------------------------------------------
// Reset values and commands
// ----------------------------------------------------------------
`define SFS_CTRL_RESET      8'h00
`define SFS_PARK_RESET      5'h1E
`define SFS_VS_PLAIN        3'h7
`define SFS_CMD_READ        8'h03
`define SFS_CMD_FAST_READ   8'h0B
`define SFS_ADDR_BYTES      8'h03

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SFS_CLK_PERIOD_NS   100
`define SFS_SCLK_HALF_NS    500
`define SFS_SCLK_HALF_CYC   ((`SFS_SCLK_HALF_NS + `SFS_CLK_PERIOD_NS - 1) / `SFS_CLK_PERIOD_NS)
`define SFS_STRAP_WAIT      2'h3

`endif

// ### src/sfs_pkg.sv
// Types shared by the shared flash select block
`default_nettype none
package sfs_pkg;

    typedef enum logic [5:0] {
        SFS_ST_WAIT = 6'b000001,
        SFS_ST_CMD  = 6'b000010,
        SFS_ST_ADDR = 6'b000100,
        SFS_ST_DATA = 6'b001000,
        SFS_ST_PAR  = 6'b010000,
        SFS_ST_DONE = 6'b100000
    } sfs_state_t;

    typedef struct packed {
        logic dac_select;
        logic preamp_select;
        logic parallel_flash_enable;
        logic platform_init;
        logic adc_convert;
    } sfs_park_t;

    typedef struct packed {
        logic       vs_oe;
        logic [2:0] vs;
        logic [1:0] spare;
        logic       select;
        logic       drive;
    } sfs_ctrl_t;

endpackage
`default_nettype wire

// ### src/sfs_shift.sv
// Byte shifter for the flash serial bus, mode 0
`default_nettype none
module sfs_shift #(
    parameter int HALF = 5
) (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       start,
    input  wire logic [7:0] tx,
    input  wire logic       miso,
    output logic            sclk,
    output logic            mosi,
    output logic            busy,
    output logic            done,
    output logic      [7:0] rx
);
    localparam int XFER = 16 * HALF;
    localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

    logic [7:0] sh;
    logic [2:0] bits;
    logic [7:0] cnt;
    wire        tick = (cnt == HALF_LAST);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sclk <= 1'b0;
            mosi <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            rx   <= 8'h00;
            sh   <= 8'h00;
            bits <= 3'h0;
            cnt  <= 8'h00;
        end else begin
            done <= 1'b0;
            if (!busy) begin
                if (start) begin
                    busy <= 1'b1;
                    sh   <= tx;
                    mosi <= tx[7];
                    bits <= 3'h0;
                    cnt  <= 8'h00;
                end
            end else if (tick) begin
                cnt <= 8'h00;
                if (!sclk) begin
                    sclk <= 1'b1;
                    rx   <= {rx[6:0], miso};
                end else begin
                    sclk <= 1'b0;
                    if (bits == 3'h7) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        bits <= bits + 3'h1;
                        sh   <= {sh[6:0], 1'b0};
                        mosi <= sh[6];
                    end
                end
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end

    msb_first_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (start && !busy) |=> (mosi == $past(tx[7])) && busy)
        else $error("shifter did not present the top bit first");

    xfer_len_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (start && !busy) |=> ##XFER done)
        else $error("byte transfer did not finish after sixteen half periods");
endmodule // sfs_shift
`default_nettype wire

// ### src/sfs_sync.sv
// Two-flop synchroniser for pin inputs
`default_nettype none
module sfs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // sfs_sync
`default_nettype wire

// ### src/sfs_top.sv
// Shared flash select, configuration read engine and APB register slave
`default_nettype none
`include "sfs_params.svh"
module sfs_top #(
    parameter int          CFG_BYTES = 4,
    parameter logic [19:0] CFG_WORDS = 20'h60000
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             parallel_config_mode,
    input  wire logic [2:0]       variant_select_in,
    output logic      [2:0]       variant_select_out,
    output logic                  variant_select_oe,
    output logic                  spi_sclk,
    output logic                  spi_sclk_oe,
    output logic                  spi_mosi,
    output logic                  spi_mosi_oe,
    input  wire logic             spi_miso,
    output logic                  config_flash_select_n,
    output logic                  config_flash_select_oe,
    output sfs_pkg::sfs_park_t    park,
    output logic                  cfg_done
);
    localparam int HALF = `SFS_SCLK_HALF_CYC;
    localparam logic [7:0] DATA_LAST = 8'(CFG_BYTES - 1);
    localparam logic [7:0] ADDR_LAST = `SFS_ADDR_BYTES - 8'h01;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] pin_s;
    wire        miso_s = pin_s[0];
    wire  [2:0] vs_s   = pin_s[3:1];
    wire        mode_s = pin_s[4];

    sfs_sync #(.WIDTH(5)) u_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .d       ({parallel_config_mode, variant_select_in, spi_miso}),
        .q       (pin_s)
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    sfs_pkg::sfs_state_t state;
    sfs_pkg::sfs_ctrl_t  ctrl;
    sfs_pkg::sfs_park_t  park_r;
    logic [1:0]          wait_cnt;
    logic [7:0]          byte_cnt;
    logic                cfg_start;
    logic [7:0]          cfg_tx;
    logic [2:0]          vs_cap;
    logic [7:0]          read_cmd;
    logic [7:0]          last_byte;
    logic [19:0]         par_addr;
    logic                par_mode;
    logic                user_start;
    logic [7:0]          user_tx;

    // ----------------------------------------------------------------
    // Shifter
    // ----------------------------------------------------------------
    logic       sh_sclk;
    logic       sh_mosi;
    logic       sh_busy;
    logic       sh_done;
    logic [7:0] sh_rx;
    wire        done_st = (state == sfs_pkg::SFS_ST_DONE);

    sfs_shift #(.HALF(HALF)) u_shift (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .start   (done_st ? user_start : cfg_start),
        .tx      (done_st ? user_tx : cfg_tx),
        .miso    (miso_s),
        .sclk    (sh_sclk),
        .mosi    (sh_mosi),
        .busy    (sh_busy),
        .done    (sh_done),
        .rx      (sh_rx)
    );

    function automatic logic [7:0] sfs_read_cmd(input logic [2:0] vs);
        sfs_read_cmd = (vs == `SFS_VS_PLAIN) ? `SFS_CMD_READ : `SFS_CMD_FAST_READ;
    endfunction

    // ----------------------------------------------------------------
    // Configuration sequence
    // ----------------------------------------------------------------
    wire serial_xfer = (state == sfs_pkg::SFS_ST_CMD) || (state == sfs_pkg::SFS_ST_ADDR) ||
                       (state == sfs_pkg::SFS_ST_DATA);
    wire serial_cfg  = serial_xfer || (state == sfs_pkg::SFS_ST_WAIT);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state     <= sfs_pkg::SFS_ST_WAIT;
            wait_cnt  <= 2'h0;
            byte_cnt  <= 8'h00;
            cfg_start <= 1'b0;
            cfg_tx    <= 8'h00;
            vs_cap    <= 3'h0;
            read_cmd  <= 8'h00;
            last_byte <= 8'h00;
            par_addr  <= 20'h00000;
            par_mode  <= 1'b0;
        end else begin
            cfg_start <= 1'b0;
            case (state)
                sfs_pkg::SFS_ST_WAIT: begin
                    if (wait_cnt != `SFS_STRAP_WAIT) begin
                        wait_cnt <= wait_cnt + 2'h1;
                    end else if (mode_s) begin
                        par_mode <= 1'b1;
                        state    <= sfs_pkg::SFS_ST_PAR;
                    end else begin
                        vs_cap    <= vs_s;
                        read_cmd  <= sfs_read_cmd(vs_s);
                        cfg_tx    <= sfs_read_cmd(vs_s);
                        cfg_start <= 1'b1;
                        state     <= sfs_pkg::SFS_ST_CMD;
                    end
                end
                sfs_pkg::SFS_ST_CMD: begin
                    if (sh_done) begin
                        cfg_tx    <= 8'h00;
                        cfg_start <= 1'b1;
                        byte_cnt  <= 8'h00;
                        state     <= sfs_pkg::SFS_ST_ADDR;
                    end
                end
                sfs_pkg::SFS_ST_ADDR: begin
                    if (sh_done) begin
                        cfg_start <= 1'b1;
                        byte_cnt  <= (byte_cnt == ADDR_LAST) ? 8'h00 : byte_cnt + 8'h01;
                        if (byte_cnt == ADDR_LAST) begin
                            state <= sfs_pkg::SFS_ST_DATA;
                        end
                    end
                end
                sfs_pkg::SFS_ST_DATA: begin
                    if (sh_done) begin
                        last_byte <= sh_rx;
                        byte_cnt  <= byte_cnt + 8'h01;
                        if (byte_cnt == DATA_LAST) begin
                            state <= sfs_pkg::SFS_ST_DONE;
                        end else begin
                            cfg_start <= 1'b1;
                        end
                    end
                end
                sfs_pkg::SFS_ST_PAR: begin
                    par_addr <= par_addr + 20'h00001;
                    if (par_addr == CFG_WORDS - 20'h00001) begin
                        state <= sfs_pkg::SFS_ST_DONE;
                    end
                end
                sfs_pkg::SFS_ST_DONE: begin
                    state <= sfs_pkg::SFS_ST_DONE;
                end
                default: begin
                    state <= sfs_pkg::SFS_ST_WAIT;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire        apb_acc   = psel & penable & ~pready;
    wire        apb_fin   = psel & penable & pready;
    wire        hit_ctrl  = (paddr == `SFS_OFS_CTRL);
    wire        hit_park  = (paddr == `SFS_OFS_PARK);
    wire        hit_data  = (paddr == `SFS_OFS_DATA);
    wire        hit_stat  = (paddr == `SFS_OFS_STATUS);
    wire        flash_sel = ctrl.select | ~config_flash_select_n | sh_busy;
    wire        park_lock = flash_sel | ~done_st;
    wire        data_lock = sh_busy | user_start | ~done_st;
    wire        bad_write = pwrite & ((hit_park & park_lock) | (hit_data & data_lock) | hit_stat);
    wire        unmapped  = ~(hit_ctrl | hit_park | hit_data | hit_stat);
    wire        apb_err   = unmapped | bad_write;
    wire        wr_ok     = apb_fin & pwrite & ~pslverr;
    wire [31:0] stat_word = {8'h00, last_byte, read_cmd, 1'b0, vs_cap, 1'b0, par_mode, sh_busy, done_st};
    wire [31:0] rd_word   = hit_ctrl ? {24'h000000, ctrl} :
                            hit_park ? {27'h0000000, park_r} :
                            hit_data ? {24'h000000, sh_rx} :
                            hit_stat ? stat_word : 32'h00000000;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= apb_acc;
            pslverr <= apb_acc & apb_err;
            prdata  <= (apb_acc & ~pwrite & ~unmapped) ? rd_word : 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl       <= `SFS_CTRL_RESET;
            park_r     <= `SFS_PARK_RESET;
            user_start <= 1'b0;
            user_tx    <= 8'h00;
        end else begin
            user_start <= wr_ok & hit_data;
            if (wr_ok & hit_ctrl) begin
                ctrl <= pwdata[7:0];
            end
            if (wr_ok & hit_park) begin
                park_r <= pwdata[4:0];
            end
            if (wr_ok & hit_data) begin
                user_tx <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin outputs
    // ----------------------------------------------------------------
    wire       next_select_n = serial_xfer ? 1'b0 : (done_st ? ~ctrl.select : 1'b1);
    wire       next_spi_oe   = serial_cfg | (done_st & ctrl.drive);
    wire [2:0] next_vs_out   = (state == sfs_pkg::SFS_ST_PAR) ? par_addr[19:17] : ctrl.vs;
    wire       next_vs_oe    = (state == sfs_pkg::SFS_ST_PAR) | (done_st & ctrl.vs_oe);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            spi_sclk               <= 1'b0;
            spi_mosi               <= 1'b0;
            spi_sclk_oe            <= 1'b0;
            spi_mosi_oe            <= 1'b0;
            config_flash_select_n  <= 1'b1;
            config_flash_select_oe <= 1'b0;
            variant_select_out     <= 3'h0;
            variant_select_oe      <= 1'b0;
            park                   <= `SFS_PARK_RESET;
            cfg_done               <= 1'b0;
        end else begin
            spi_sclk               <= sh_sclk;
            spi_mosi               <= sh_mosi;
            spi_sclk_oe            <= next_spi_oe;
            spi_mosi_oe            <= next_spi_oe;
            config_flash_select_n  <= next_select_n;
            config_flash_select_oe <= next_spi_oe;
            variant_select_out     <= next_vs_out;
            variant_select_oe      <= next_vs_oe;
            park                   <= park_r;
            cfg_done               <= done_st;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    release_pins_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (done_st && ctrl.drive) |=> (spi_sclk_oe && spi_mosi_oe && config_flash_select_oe))
        else $error("flash pins not handed to the application after configuration");

    vs_sample_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(state == sfs_pkg::SFS_ST_CMD) |-> (vs_cap == $past(vs_s)) && !variant_select_oe)
        else $error("variant select not sampled at start of serial configuration");

    read_cmd_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (serial_xfer && vs_cap == `SFS_VS_PLAIN) |-> (read_cmd == `SFS_CMD_READ))
        else $error("all-ones variant select did not pick the plain read command");

    par_addr_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (state == sfs_pkg::SFS_ST_PAR) |=> variant_select_oe && (variant_select_out == $past(par_addr[19:17])))
        else $error("variant select pins not carrying upper parallel address");

    user_vs_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (done_st && $past(done_st)) |=> (variant_select_oe == $past(ctrl.vs_oe)) &&
                                        (variant_select_out == $past(ctrl.vs)))
        else $error("variant select pins not under user control after configuration");

    select_low_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (serial_xfer && sh_busy) |=> !config_flash_select_n [*2])
        else $error("flash select rose during a configuration access");
endmodule // sfs_top
`default_nettype wire

// ### verif/sfs_flash_model.sv
// Behavioural serial flash that sits on the shared bus
`default_nettype none
module sfs_flash_model (
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       mosi,
    output logic            miso,
    output logic      [7:0] first_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    // Write protect and hold are tied high on the board, so they are not pins here
    logic [7:0] rx_sr;
    logic [7:0] tx_sr;
    int         bit_cnt;
    int         byte_cnt;
    initial begin
        miso = 1'b0;
        first_byte = 8'h00;
    end
    always @(negedge cs_n) begin
        bit_cnt = 0;
        byte_cnt = 0;
    end
    // Released line shows the inverse of its last value
    always @(posedge cs_n) miso = ~miso;
    always @(posedge sclk) if (!cs_n) begin
        rx_sr = {rx_sr[6:0], mosi};
        bit_cnt = (bit_cnt + 1) % 8;
        if (bit_cnt == 0) begin
            if (byte_cnt == 0) first_byte = rx_sr;
            byte_cnt++;
        end
    end
    // Data bytes follow the command and three address bytes
    always @(negedge sclk) if (!cs_n && byte_cnt >= 4) begin
        if (bit_cnt == 0) tx_sr = 8'hC3 ^ 8'(byte_cnt);
        miso = tx_sr[7];
        tx_sr = {tx_sr[6:0], 1'b0};
    end
endmodule // sfs_flash_model
`default_nettype wire

// ### verif/test_sfs_top.sv
// Self-checking bench for the shared flash select block
`default_nettype none
module test_sfs_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic               ref_clk = 1'b0;
    logic               nrst = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0000_0000;
    logic               parallel_config_mode = 1'b0;
    logic [2:0]         vs_strap = 3'h7;
    logic [2:0]         vs_wire;
    logic [31:0]        prdata;
    logic [31:0]        rd;
    logic [2:0]         variant_select_out;
    logic [7:0]         first_byte;
    logic               pready, pslverr, variant_select_oe, spi_sclk, spi_sclk_oe, spi_mosi, spi_mosi_oe;
    logic               spi_miso, config_flash_select_n, config_flash_select_oe, cfg_done, err, sclk_w, cs_w;
    sfs_pkg::sfs_park_t park;
    int                 bad_count = 0;
    int                 checks = 0;
    // Board straps hold the variant-select lines at vs_strap when nobody drives them
    assign vs_wire = variant_select_oe ? variant_select_out : vs_strap;
    assign sclk_w  = spi_sclk_oe & spi_sclk;
    assign cs_w    = config_flash_select_oe ? config_flash_select_n : 1'b1;
    always #50 ref_clk = ~ref_clk;
    sfs_top #(.CFG_BYTES(4), .CFG_WORDS(20'h40)) u_sfs_top (
        .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .parallel_config_mode(parallel_config_mode), .variant_select_in(vs_wire),
        .variant_select_out(variant_select_out), .variant_select_oe(variant_select_oe),
        .spi_sclk(spi_sclk), .spi_sclk_oe(spi_sclk_oe), .spi_mosi(spi_mosi), .spi_mosi_oe(spi_mosi_oe),
        .spi_miso(spi_miso), .config_flash_select_n(config_flash_select_n),
        .config_flash_select_oe(config_flash_select_oe), .park(park), .cfg_done(cfg_done));
    sfs_flash_model u_sfs_flash_model (
        .sclk(sclk_w), .cs_n(cs_w), .mosi(spi_mosi), .miso(spi_miso), .first_byte(first_byte));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) bad_count++;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, 8'h0C, 32'h0);
            n++;
        end while (rd[1] !== 1'b0 && n < 60);
        if (n >= 60) bad_count++;
    endtask
    task automatic send(input logic [7:0] b);
        apb(1'b1, 8'h08, 32'(b));
        check(32'(err), 32'h0);
        wait_idle;
    endtask
    task automatic boot(input logic par, input logic [2:0] vs);
        nrst <= 1'b0;
        parallel_config_mode <= par;
        vs_strap <= vs;
        repeat (10) @(posedge ref_clk);
        check(32'(park), 32'h1E);
        nrst <= 1'b1;
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        while (cfg_done !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 3000) bad_count++;
    endtask
    task automatic close_out;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_boot(input logic [2:0] vs, input logic [7:0] cmd, input logic [7:0] last);
        boot(1'b0, vs);
        wait_done;
        apb(1'b0, 8'h0C, 32'h0);
        check(32'(rd[15:8]), 32'(cmd));
        check(32'(rd[6:4]), 32'(vs));
        check(32'(rd[23:16]), 32'(last));
        check(32'(first_byte), 32'(cmd));
        check(32'({spi_sclk_oe, spi_mosi_oe, config_flash_select_oe}), 32'h0);
    endtask
    task automatic t_user;
        apb(1'b1, 8'h00, 32'h3);
        repeat (2) @(posedge ref_clk);
        check(32'({spi_sclk_oe, config_flash_select_oe, config_flash_select_n}), 32'h6);
        apb(1'b1, 8'h04, 32'h1F);
        check(32'({err, park}), 32'h3E);
        send(8'h03);
        send(8'h00);
        send(8'h00);
        send(8'h00);
        apb(1'b1, 8'h08, 32'hFF);
        apb(1'b1, 8'h08, 32'h00);
        check(32'(err), 32'h1);
        wait_idle;
        apb(1'b0, 8'h08, 32'h0);
        check(32'(rd[7:0]), 32'hC7);
        check(32'(first_byte), 32'h03);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, 32'h1F);
        repeat (2) @(posedge ref_clk);
        check(32'({err, park}), 32'h1F);
        apb(1'b1, 8'h04, 32'h1E);
        apb(1'b0, 8'h10, 32'h0);
        check({31'h0, err} ^ rd, 32'h1);
        apb(1'b1, 8'h0C, 32'h0);
        check(32'(err), 32'h1);
    endtask
    task automatic t_variant;
        apb(1'b1, 8'h00, 32'hA0);
        repeat (2) @(posedge ref_clk);
        check(32'({variant_select_oe, variant_select_out}), 32'hA);
    endtask
    task automatic t_parallel;
        boot(1'b1, 3'h7);
        repeat (12) @(posedge ref_clk);
        check(32'({variant_select_oe, variant_select_out}), 32'h8);
        wait_done;
        apb(1'b0, 8'h0C, 32'h0);
        check(32'(rd[2:0]), 32'h5);
    endtask
    initial begin
        t_boot(3'h7, 8'h03, 8'hC4);
        t_user;
        t_variant;
        t_boot(3'h5, 8'h0B, 8'hC4);
        t_parallel;
        close_out;
    end
    initial begin
        #2000000;
        bad_count++;
        close_out;
    end
endmodule // test_sfs_top
`default_nettype wire
